// *** tb/tmr_core_monitor.sv ***
`timescale 1ns/1ps
module tmr_core_monitor
   import tmr_pkg::*;
(
   // clock and reset
   input wire logic              MCLK,
   input wire logic              RST,
   // apb
   input wire logic              PSEL,
   input wire logic              PENABLE,
   input wire logic              PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [DATA_W-1:0] PWDATA,
   input wire logic              PREADY,
   input wire logic              PSLVERR,
   input wire logic [DATA_W-1:0] PRDATA,
   // interrupt
   input wire logic              IRQ
);
   // ---------------------------------------------------------------
   // shadow of the run mode, taken from completed control writes
   // ---------------------------------------------------------------
   logic [1:0] mode_q;  // run mode as software last set it
   logic [1:0] mode_d;  // next shadow value
   logic       rd_cnt;  // completed read of the count
   assign rd_cnt = PREADY && PSEL && !PWRITE && PADDR == OFS_COUNT;
   always_comb begin
      mode_d = mode_q;
      if (PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_CTRL) begin
         mode_d = PWDATA[CTL_MODE_LO +: 2];
      end
   end
   always_ff @(posedge MCLK) begin
      mode_q <= RST ? MODE_STOP : mode_d;
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   AST_READY_ONE_WAIT: assert property (PSEL && $rose(PENABLE) |=> PREADY)
      else $error("ready not in second access cycle");
   AST_READY_PULSE: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   AST_ERR_EMPTY: assert property (PSLVERR |-> PREADY && PRDATA == '0)
      else $error("error without ready or with data");
   AST_IDLE_DATA: assert property (!PREADY |-> PRDATA == DATA_ZERO)
      else $error("read data outside a transfer");
   AST_COUNT_WIDTH: assert property (rd_cnt |-> PRDATA[31:16] == '0)
      else $error("count wider than sixteen bits");
   AST_STOP_READS_ZERO: assert property (
      rd_cnt && mode_q == MODE_STOP |-> PRDATA == DATA_ZERO)
      else $error("stopped count read not zero");
   AST_FREE_ADVANCE: assert property (
      rd_cnt && mode_q == MODE_FREE && $past(rd_cnt, 4)
      && $past(mode_q, 4) == MODE_FREE
      |-> PRDATA[15:0] == 16'($past(PRDATA[15:0], 4) + 16'h0004))
      else $error("count did not advance by four");
   AST_RESET_QUIET: assert property ($fell(RST) |-> !PREADY && !IRQ)
      else $error("outputs active after reset");
endmodule // tmr_core_monitor

bind tmr_core tmr_core_monitor i_tmr_core_monitor (.MCLK(MCLK), .RST(RST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
   .IRQ(IRQ));

// *** tb/tmr_core_tb.sv ***
`timescale 1ns/1ps
module tmr_core_tb;
   import tmr_pkg::*;
   logic              MCLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [ADDR_W-1:0] PADDR = '0;
   logic [DATA_W-1:0] PWDATA = '0, PRDATA, rv, v;
   logic              PREADY, PSLVERR, IRQ, er, f1 = 0, f2 = 0, ti1, ti2;
   int                error_cnt = 0, n_compared = 0;
   always #2 MCLK = ~MCLK;
   tmr_core i_tmr_core (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
      .TIMER_INPUT_FIRST(ti1), .TIMER_INPUT_SECOND(ti2), .IRQ(IRQ));
   tmr_pin_source i_tmr_pin_source (.clk(MCLK), .fire_first(f1),
      .fire_second(f2), .pin_first(ti1), .pin_second(ti2));
   // ---------------------------------------------------------------
   // helpers: compare, apb transfer, input pulse
   // ---------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until ready seen high at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      PSEL <= 1;
      PENABLE <= 0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1;
      // ready, data and error all taken at the completing rising edge
      @(posedge MCLK);
      while (PREADY !== 1'b1) @(posedge MCLK);
      rv = PRDATA;
      er = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
   endtask
   task fire(input bit second);
      @(posedge MCLK);
      f1 <= !second;
      f2 <= second;
      @(posedge MCLK);
      f1 <= 0;
      f2 <= 0;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_reset;
      apb(0, OFS_COUNT, 0); chk(rv, 0);
      apb(0, OFS_IRQ_STAT, 0); chk(rv, 0);
      apb(0, 8'h1C, 0); chk(er, 1);
      chk(rv, 0);
      chk(IRQ, 0);
   endtask
   task t_free;  // cc2 in capture use, yet reads must not capture
      apb(1, OFS_CTRL, 32'h0000_0084);
      apb(0, OFS_COUNT, 0); v = rv;
      apb(0, OFS_COUNT, 0); chk(rv - v, 4);
      v = rv;
      apb(1, OFS_COUNT, 32'h0000_FFFF);
      apb(0, OFS_COUNT, 0); chk(rv - v, 8);
      apb(0, OFS_CC_SEC, 0); chk(rv, 0);
      apb(1, OFS_CTRL, 0);
      apb(0, OFS_COUNT, 0); chk(rv, 0);
   endtask
   task t_wrap;  // overflow raised, masked, cleared
      apb(1, OFS_IRQ_EN, 32'h0000_0004);
      apb(1, OFS_CTRL, 32'h0000_0004);
      repeat (65600) @(posedge MCLK);
      chk(IRQ, 1);
      apb(1, OFS_IRQ_EN, 0);
      repeat (2) @(posedge MCLK);
      chk(IRQ, 0);
      apb(1, OFS_CTRL, 0);
      apb(0, OFS_IRQ_STAT, 0); chk(rv & 4, 4);
      apb(1, OFS_IRQ_CLR, 32'h0000_001F);
      apb(0, OFS_IRQ_STAT, 0); chk(rv, 0);
   endtask
   task t_match;  // period of compare value plus one
      apb(1, OFS_CC_FIRST, 32'h0000_0014);
      apb(1, OFS_CTRL, 32'h0000_000C);
      repeat (12) begin
         apb(0, OFS_COUNT, 0); chk(rv <= 32'h14, 1);
      end
      apb(0, OFS_IRQ_STAT, 0); chk(rv & 1, 1);
      apb(1, OFS_CTRL, 0);
   endtask
   task t_edge;  // first input rise clears count, captures into cc2
      apb(1, OFS_CTRL, 32'h0000_0188);
      repeat (40) @(posedge MCLK);
      fire(0);
      apb(0, OFS_COUNT, 0); chk(rv < 16, 1);
      apb(0, OFS_CC_SEC, 0); chk(rv > 40, 1);
      apb(1, OFS_CTRL, 0);
   endtask
   task t_oneshot;  // software trigger, then a falling first input
      apb(1, OFS_CTRL, 32'h0000_0014);
      repeat (40) @(posedge MCLK);
      apb(1, OFS_CTRL, 32'h0000_0034);
      apb(0, OFS_COUNT, 0); chk(rv < 16, 1);
      apb(0, OFS_CTRL, 0); chk(rv, 32'h0000_0014);
      repeat (40) @(posedge MCLK);
      fire(0);
      // the falling edge only comes once the pulse has ended
      repeat (4) @(posedge MCLK);
      apb(0, OFS_COUNT, 0); chk(rv < 16, 1);
      apb(1, OFS_CTRL, 0);
   endtask
   task t_capture;  // captured value survives stop and mode change
      apb(1, OFS_CTRL, 32'h0000_0444);
      repeat (30) @(posedge MCLK);
      fire(1);
      apb(0, OFS_CC_FIRST, 0); chk(rv > 20, 1);
      v = rv;
      apb(1, OFS_CTRL, 32'h0000_0040);
      apb(0, OFS_CC_FIRST, 0); chk(rv, v);
      apb(1, OFS_CTRL, 0);
      apb(0, OFS_CC_FIRST, 0); chk(rv, v);
      apb(1, OFS_CC_FIRST, 32'h0000_0005);
      apb(0, OFS_CC_FIRST, 0); chk(rv, 32'h0000_0005);
   endtask
   // ---------------------------------------------------------------
   // verdict, watchdog, main sequence
   // ---------------------------------------------------------------
   task wrap_up;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge MCLK);
      error_cnt++;
      wrap_up;
   end
   initial begin
      repeat (2) @(posedge MCLK);
      RST <= 0;
      t_reset;
      t_free;
      t_wrap;
      t_match;
      t_edge;
      t_oneshot;
      t_capture;
      wrap_up;
   end
endmodule // tmr_core_tb

// *** tb/tmr_pin_source.sv ***
`timescale 1ns/1ps
module tmr_pin_source #(
   parameter int HI_CYC = 3  // pulse width in clocks
) (
   // clock
   input wire logic clk,
   // one-cycle pulse requests
   input wire logic fire_first,
   input wire logic fire_second,
   // pins toward the timer, idle low
   output logic     pin_first,
   output logic     pin_second
);
   // ---------------------------------------------------------------
   // pulse stretchers: one rise, then one fall after HI_CYC clocks
   // ---------------------------------------------------------------
   int cnt1 = 0;  // first pin high time left
   int cnt2 = 0;  // second pin high time left
   always @(posedge clk) begin
      cnt1 <= fire_first ? HI_CYC : (cnt1 > 0 ? cnt1 - 1 : 0);
      cnt2 <= fire_second ? HI_CYC : (cnt2 > 0 ? cnt2 - 1 : 0);
   end
   assign pin_first = cnt1 > 0;
   // shared pin only ever driven as an input here, never as an output
   assign pin_second = cnt2 > 0;
endmodule // tmr_pin_source

// *** verilog/tmr_apb_front.sv ***
`timescale 1ns/1ps
module tmr_apb_front
   import tmr_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic                   pready_q,
   output logic                   pslverr_q,
   output logic [DATA_W-1:0]      prdata_q,
   // register file side
   tmr_regbus_if.front            bus
);
   logic              pready_d;   // next ready
   logic              pslverr_d;  // next error
   logic [DATA_W-1:0] prdata_d;   // next read data
   logic              wait_c;     // first access cycle

   // ------------------------------------------------------------------
   // access phase: one wait state, then ready with data
   // ------------------------------------------------------------------
   // the wait state lets read data come out of a flip-flop
   always_comb begin
      wait_c     = psel & penable & ~pready_q;
      pready_d   = wait_c;
      pslverr_d  = wait_c & ~bus.hit;            // unmapped offset
      prdata_d   = DATA_ZERO;
      if (wait_c & ~pwrite & bus.hit) begin
         prdata_d = bus.rdata;
      end
      bus.addr   = paddr;
      bus.wdata  = pwdata;
      // write lands on the completing edge only
      bus.wr_en  = psel & penable & pready_q & pwrite & bus.hit;
      bus.rd_en  = wait_c & ~pwrite;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= DATA_ZERO;
      end else begin
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end
endmodule : tmr_apb_front

// *** verilog/tmr_core.sv ***
`timescale 1ns/1ps
// What this block does
// - count register is 16-bit, read only
// - count advances each count clock while running
// - running: count read returns current count
// - stopped: count read returns zero
// - reset or stop forces count zero
// - edge-clear mode: first input edge zeroes
// - match-clear mode: match with first cc zeroes
// - one-shot: trigger or first edge zeroes count
// - stop colliding with capture: capture takes the count as it stands
// - captured value persists until capture, software write or reset
// - count read has no side effect
// - mode 00 stops and clears; 01 free-runs
// - counting starts on nonzero mode, stops on 00
// - compare match raises first match interrupt
module tmr_core
   import tmr_pkg::*;
(
   // clock and reset
   input  wire logic              MCLK,
   input  wire logic              RST,
   // apb slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [DATA_W-1:0] PWDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   output logic [DATA_W-1:0]      PRDATA,
   // timer input pins
   input  wire logic              TIMER_INPUT_FIRST,
   input  wire logic              TIMER_INPUT_SECOND,
   // interrupt
   output logic                   IRQ
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [CNT_W-1:0]  count_q;       // running count
   logic [CNT_W-1:0]  count_d;       // next count
   logic [CTRL_W-1:0] ctrl_q;        // mode control bits
   logic [CTRL_W-1:0] ctrl_d;        // next control
   logic [CNT_W-1:0]  cc_first_q;    // first capture/compare
   logic [CNT_W-1:0]  cc_first_d;    // next first cc
   logic [CNT_W-1:0]  cc_sec_q;      // second capture/compare
   logic [CNT_W-1:0]  cc_sec_d;      // next second cc
   logic [IRQ_W-1:0]  stat_q;        // sticky events
   logic [IRQ_W-1:0]  stat_d;        // next status
   logic [IRQ_W-1:0]  irq_en_q;      // event enables
   logic [IRQ_W-1:0]  irq_en_d;      // next enables
   logic              irq_q;         // interrupt output flop
   logic              irq_d;         // next interrupt

   // ------------------------------------------------------------------
   // decoded helpers
   // ------------------------------------------------------------------
   logic [1:0]        mode;          // current run mode
   logic              running;       // mode is not stop
   logic              edge_first;    // valid edge on first input
   logic              edge_sec;      // valid edge on second input
   logic              match_first;   // count equals first cc, compare use
   logic              match_sec;     // count equals second cc, compare use
   logic              wrap;          // count about to wrap
   logic              cap_first;     // capture into first cc
   logic              cap_sec;       // capture into second cc
   logic              os_trig;       // one-shot trigger written
   logic              wr_ctrl;       // control write strobe
   logic [IRQ_W-1:0]  evt;           // this cycle's events
   logic [1:0]        edge_sel [2];  // per input edge selection
   logic              edge_pin [2];  // per input pin level
   logic              edge_hit [2];  // per input detected edge

   tmr_regbus_if bus ();

   // ------------------------------------------------------------------
   // register decode, used by the write paths; the read mux decodes with its own case
   // ------------------------------------------------------------------
   function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
      is_reg = (a == ofs);
   endfunction

   // ------------------------------------------------------------------
   // apb front end
   // ------------------------------------------------------------------
   tmr_apb_front u_front (
      .clk       (MCLK),
      .rst       (RST),
      .psel      (PSEL),
      .penable   (PENABLE),
      .pwrite    (PWRITE),
      .paddr     (PADDR),
      .pwdata    (PWDATA),
      .pready_q  (PREADY),
      .pslverr_q (PSLVERR),
      .prdata_q  (PRDATA),
      .bus       (bus.front)
   );

   // ------------------------------------------------------------------
   // input edge detection, one per timer input pin
   // ------------------------------------------------------------------
   // pins are taken as synchronous, so no extra synchroniser here
   always_comb begin
      edge_pin[0] = TIMER_INPUT_FIRST;
      edge_pin[1] = TIMER_INPUT_SECOND;
      edge_sel[0] = ctrl_q[CTL_ES1_LO +: 2];
      edge_sel[1] = ctrl_q[CTL_ES2_LO +: 2];
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_edge
         tmr_edge_detect u_edge (
            .clk   (MCLK),
            .rst   (RST),
            .pin   (edge_pin[gi]),
            .sel   (edge_sel[gi]),
            .pulse (edge_hit[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // event decode
   // ------------------------------------------------------------------
   always_comb begin
      mode        = ctrl_q[CTL_MODE_LO +: 2];
      running     = (mode != MODE_STOP);
      edge_first  = edge_hit[0] & running;
      edge_sec    = edge_hit[1] & running;
      // compare only in compare use; capture use never matches
      match_first = running & ~ctrl_q[CTL_CC1_CAP]
                  & (count_q == cc_first_q);
      match_sec   = running & ~ctrl_q[CTL_CC2_CAP]
                  & (count_q == cc_sec_q);
      wrap        = running & (count_q == CNT_MAX);
      // first cc catches on the second input, second cc on the first
      cap_first   = ctrl_q[CTL_CC1_CAP] & edge_sec;
      cap_sec     = ctrl_q[CTL_CC2_CAP] & edge_first;
      wr_ctrl     = bus.wr_en & is_reg(bus.addr, OFS_CTRL);
      os_trig     = wr_ctrl & running & ctrl_q[CTL_ONE_SHOT]
                  & bus.wdata[CTL_OS_TRIG];
      evt              = IRQ_ZERO;
      evt[IRQ_MATCH1]  = match_first;
      evt[IRQ_MATCH2]  = match_sec;
      evt[IRQ_OVF]     = wrap;
      evt[IRQ_CAP1]    = cap_first;
      evt[IRQ_CAP2]    = cap_sec;
   end

   // ------------------------------------------------------------------
   // counter next value
   // ------------------------------------------------------------------
   // clears take priority over the increment; a stop wins over all
   always_comb begin
      count_d = count_q + CNT_ONE;
      if (!running) begin
         count_d = CNT_ZERO;
      end else if (ctrl_q[CTL_ONE_SHOT] & (os_trig | edge_first)) begin
         count_d = CNT_ZERO;
      end else if ((mode == MODE_CLR_EDGE) & edge_first) begin
         count_d = CNT_ZERO;
      end else if ((mode == MODE_CLR_MTCH) & match_first) begin
         count_d = CNT_ZERO;
      end else if (wrap) begin
         count_d = CNT_ZERO;
      end
      // a write stopping the timer clears at once
      if (wr_ctrl & (bus.wdata[CTL_MODE_LO +: 2] == MODE_STOP)) begin
         count_d = CNT_ZERO;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         count_q <= CNT_ZERO;
      end else begin
         count_q <= count_d;
      end
   end

   // ------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------
   // the trigger bit is never stored, it only acts in its write cycle
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = bus.wdata[CTRL_W-1:0];
         ctrl_d[CTL_OS_TRIG] = 1'b0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         ctrl_q <= CTRL_RST;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // ------------------------------------------------------------------
   // capture/compare registers
   // ------------------------------------------------------------------
   // capture beats a software write in the same cycle; a capture that
   // meets a stop simply takes the count as it stands
   always_comb begin
      cc_first_d = cc_first_q;
      cc_sec_d   = cc_sec_q;
      if (bus.wr_en & is_reg(bus.addr, OFS_CC_FIRST)) begin
         cc_first_d = bus.wdata[CNT_W-1:0];
      end
      if (bus.wr_en & is_reg(bus.addr, OFS_CC_SEC)) begin
         cc_sec_d = bus.wdata[CNT_W-1:0];
      end
      if (cap_first) begin
         cc_first_d = count_q;
      end
      if (cap_sec) begin
         cc_sec_d = count_q;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         cc_first_q <= CNT_ZERO;
         cc_sec_q   <= CNT_ZERO;
      end else begin
         cc_first_q <= cc_first_d;
         cc_sec_q   <= cc_sec_d;
      end
   end

   // ------------------------------------------------------------------
   // interrupt status, enable and output
   // ------------------------------------------------------------------
   // a new event wins over a clear aimed at the same bit
   always_comb begin
      stat_d   = stat_q;
      irq_en_d = irq_en_q;
      if (bus.wr_en & is_reg(bus.addr, OFS_IRQ_CLR)) begin
         stat_d = stat_q & ~bus.wdata[IRQ_W-1:0];
      end
      stat_d = stat_d | evt;
      if (bus.wr_en & is_reg(bus.addr, OFS_IRQ_EN)) begin
         irq_en_d = bus.wdata[IRQ_W-1:0];
      end
      irq_d = |(stat_d & irq_en_d);
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         stat_q   <= IRQ_ZERO;
         irq_en_q <= IRQ_ZERO;
         irq_q    <= 1'b0;
      end else begin
         stat_q   <= stat_d;
         irq_en_q <= irq_en_d;
         irq_q    <= irq_d;
      end
   end

   assign IRQ = irq_q;

   // ------------------------------------------------------------------
   // read mux, pure: reading changes no state
   // ------------------------------------------------------------------
   always_comb begin
      bus.rdata = DATA_ZERO;
      bus.hit   = 1'b1;
      case (bus.addr)
         OFS_COUNT: begin
            if (running) begin
               bus.rdata[CNT_W-1:0] = count_q;
            end else begin
               bus.rdata[CNT_W-1:0] = CNT_ZERO;
            end
         end
         OFS_CTRL:     bus.rdata[CTRL_W-1:0] = ctrl_q;
         OFS_CC_FIRST: bus.rdata[CNT_W-1:0]  = cc_first_q;
         OFS_CC_SEC:   bus.rdata[CNT_W-1:0]  = cc_sec_q;
         OFS_IRQ_STAT: bus.rdata[IRQ_W-1:0]  = stat_q;
         OFS_IRQ_CLR:  bus.rdata = DATA_ZERO;   // write only
         OFS_IRQ_EN:   bus.rdata[IRQ_W-1:0]  = irq_en_q;
         default:      bus.hit = 1'b0;          // unmapped
      endcase
   end

endmodule : tmr_core

// *** verilog/tmr_edge_detect.sv ***
`timescale 1ns/1ps
module tmr_edge_detect
   import tmr_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // pin and selection
   input  wire logic       pin,
   input  wire logic [1:0] sel,
   // detected edge
   output logic            pulse
);
   logic prev_q;   // pin one cycle ago
   logic prev_d;   // next value

   // ------------------------------------------------------------------
   // previous level
   // ------------------------------------------------------------------
   always_comb begin
      prev_d = pin;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end

   // ------------------------------------------------------------------
   // edge decode; unused select code detects nothing
   // ------------------------------------------------------------------
   always_comb begin
      case (sel)
         EDGE_FALL: pulse = prev_q & ~pin;   // high to low
         EDGE_RISE: pulse = ~prev_q & pin;   // low to high
         EDGE_BOTH: pulse = prev_q ^ pin;    // any change
         default:   pulse = 1'b0;            // reserved code
      endcase
   end
endmodule : tmr_edge_detect

// *** verilog/tmr_pkg.sv ***
package tmr_pkg;
   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int CNT_W  = 16;               // count and capture width
   localparam int ADDR_W = 8;                // decoded apb address bits
   localparam int DATA_W = 32;               // apb data width
   localparam int IRQ_W  = 5;                // number of sticky events

   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_COUNT    = 8'h00;  // count value, ro
   localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h04;  // mode control
   localparam logic [ADDR_W-1:0] OFS_CC_FIRST = 8'h08;  // capture/compare 1
   localparam logic [ADDR_W-1:0] OFS_CC_SEC   = 8'h0C;  // capture/compare 2
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;  // sticky status, ro
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 8'h14;  // clear, wo
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h18;  // enable, rw

   // ------------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------------
   localparam int CTRL_W         = 12;       // implemented control bits
   localparam int CTL_MODE_LO    = 2;        // run mode, bits 3:2
   localparam int CTL_ONE_SHOT   = 4;        // one-shot pulse mode enable
   localparam int CTL_OS_TRIG    = 5;        // one-shot trigger, self clears
   localparam int CTL_CC1_CAP    = 6;        // first cc: 1 capture, 0 compare
   localparam int CTL_CC2_CAP    = 7;        // second cc: 1 capture
   localparam int CTL_ES1_LO     = 8;        // first input edge, bits 9:8
   localparam int CTL_ES2_LO     = 10;       // second input edge, bits 11:10
   localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;  // after reset

   // run mode encodings
   localparam logic [1:0] MODE_STOP     = 2'h0;  // stopped, count zero
   localparam logic [1:0] MODE_FREE     = 2'h1;  // free running
   localparam logic [1:0] MODE_CLR_EDGE = 2'h2;  // clear on first input edge
   localparam logic [1:0] MODE_CLR_MTCH = 2'h3;  // clear on first cc match

   // edge select encodings
   localparam logic [1:0] EDGE_FALL = 2'h0;      // falling edge
   localparam logic [1:0] EDGE_RISE = 2'h1;      // rising edge
   localparam logic [1:0] EDGE_BOTH = 2'h2;      // both edges

   // ------------------------------------------------------------------
   // interrupt status bit positions
   // ------------------------------------------------------------------
   localparam int IRQ_MATCH1 = 0;            // count equals first cc
   localparam int IRQ_MATCH2 = 1;            // count equals second cc
   localparam int IRQ_OVF    = 2;            // overflow flag
   localparam int IRQ_CAP1   = 3;            // capture into first cc
   localparam int IRQ_CAP2   = 4;            // capture into second cc

   // ------------------------------------------------------------------
   // reset values and constants
   // ------------------------------------------------------------------
   localparam logic [CNT_W-1:0]  CNT_ZERO = 16'h0000;  // cleared count
   localparam logic [CNT_W-1:0]  CNT_MAX  = 16'hFFFF;  // wrap point
   localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;  // increment
   localparam logic [IRQ_W-1:0]  IRQ_ZERO = 5'h00;     // no events
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;  // idle bus
endpackage : tmr_pkg

// *** verilog/tmr_regbus_if.sv ***
`timescale 1ns/1ps
interface tmr_regbus_if;
   import tmr_pkg::*;
   logic              wr_en;   // one-cycle write strobe
   logic              rd_en;   // one-cycle read strobe
   logic [ADDR_W-1:0] addr;    // byte offset
   logic [DATA_W-1:0] wdata;   // write data
   logic [DATA_W-1:0] rdata;   // read data from register file
   logic              hit;     // offset is mapped
   modport front (output wr_en, rd_en, addr, wdata, input rdata, hit);
   modport regs  (input wr_en, rd_en, addr, wdata, output rdata, hit);
endinterface : tmr_regbus_if
